// *** logic/erf_pkg.sv ***
// Purpose: Shared constants for the embedded RAM/FIFO block
// Assumes: Avalon-MM byte addresses, 32-bit data words
// Notes: Overview list below uses the tags found in the logic
// Overview of operation
// R1: 4608-bit block, configurable as RAM or FIFO
// R2: Both ports act only on clock edges
// R3: Write and read clocks fully independent
// R4: FIFO controller makes addresses and four flags
// R5: Synchronised pointers; no overflow, no underflow
// R6: RAM mode uses external addresses only
// R7: FIFO mode muxes controller addresses into array
// R8: Polarity-programmable enables decode up to 16 blocks
// R9: Shared buses joined between cascaded blocks
// R10: Single block supports a 4096-deep FIFO
// R11: Read data pipelined or non-pipelined by configuration
// R12: Clear resets pointers and forces flag states
package erf_pkg;
   // Storage and default shape
   localparam int CAPACITY_BITS = 4608;
   localparam int DATA_W_DEF = 9;
   localparam int ADDR_W_DEF = 9;
   localparam int BLK_SEL_W = 4;
   localparam int THR_MARGIN = 1;
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_POL = 5'h04;
   localparam logic [4:0] OFS_ALMOST_FULL_FLAG = 5'h08;
   localparam logic [4:0] OFS_ALMOST_EMPTY_FLAG = 5'h0C;
   localparam logic [4:0] OFS_LEVEL = 5'h10;
   localparam logic [4:0] OFS_STAT = 5'h14;
   localparam logic [4:0] OFS_CLR = 5'h18;
   localparam logic [4:0] OFS_IEN = 5'h1C;
   // Control fields and reset values
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_PIPE_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [7:0] POL_RST = 8'hFF;
   localparam int LEVEL_FULL_BIT = 16;
   localparam int LEVEL_ALMOST_FULL_FLAG_BIT = 17;
   // Event bits of status, clear and enable
   localparam int EV_W = 4;
   localparam int EV_OVF = 0;
   localparam int EV_UNF = 1;
   localparam int EV_FULL = 2;
   localparam int EV_ALMOST_FULL_FLAG = 3;
   localparam logic [3:0] IEN_RST = 4'h0;
endpackage

// *** logic/erf_sync.sv ***
// Purpose: Two-stage synchroniser for levels and gray words
// Assumes: Multi-bit input changes one bit at a time or is static
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module erf_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Crossing data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;

   // Metastability filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         q <= '0;
      end else begin
         s1_q <= d;
         q <= s1_q;
      end
   end
endmodule

// *** logic/erf_ram_fifo.sv ***
// Purpose: Dual-clock block RAM with built-in FIFO controller
// Assumes: clk is write and bus clock, rclk is read clock
// Notes: Config crossing to rclk assumes software changes it idle
`timescale 1ns/10ps
module erf_ram_fifo #(
   parameter int DATA_W = erf_pkg::DATA_W_DEF,
   parameter int ADDR_W = erf_pkg::ADDR_W_DEF // R10
) (
   // Write and bus clock, reset
   input wire logic clk,
   input wire logic rst,
   // Read clock
   input wire logic rclk,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Write port
   input wire logic [DATA_W-1:0] write_data_bus,
   input wire logic [ADDR_W-1:0] write_addr,
   input wire logic wr_en,
   input wire logic [erf_pkg::BLK_SEL_W-1:0] wr_blk_en,
   // Read port
   input wire logic [ADDR_W-1:0] read_addr,
   input wire logic rd_en,
   input wire logic [erf_pkg::BLK_SEL_W-1:0] rd_blk_en,
   output logic [DATA_W-1:0] rd_data,
   // FIFO clear and flags
   input wire logic fifo_clr,
   output logic full_flag,
   output logic almost_full_flag,
   output logic empty_flag,
   output logic almost_empty_flag,
   // Interrupt
   output logic irq
);
   localparam int PW = ADDR_W + 1;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int CW = 2 + erf_pkg::BLK_SEL_W + PW + 1;
   localparam logic [PW-1:0] AF_RST = PW'(DEPTH - erf_pkg::THR_MARGIN);
   localparam logic [PW-1:0] AE_RST = PW'(erf_pkg::THR_MARGIN);

   function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction
   // Each binary bit is the parity of the gray bits at and above it; no index leaves the word
   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      for (int i = 0; i < PW; i++) begin
         b[i] = ^(g >> i);
      end
      gray2bin = b;
   endfunction

   // Storage, written on clk and read on rclk
   logic [DATA_W-1:0] mem [DEPTH]; // R1

   // Bus-side registers
   logic wait_q;
   logic [31:0] rdata_q;
   logic [1:0] ctrl_q;
   logic [7:0] pol_q;
   logic [PW-1:0] almost_full_flag_thr_q;
   logic [PW-1:0] almost_empty_flag_thr_q;
   logic [erf_pkg::EV_W-1:0] stat_q;
   logic [erf_pkg::EV_W-1:0] ien_q;
   logic irq_q;
   // Write-side controller state
   logic [PW-1:0] wptr_q;
   logic [PW-1:0] wgray_q;
   logic [PW-1:0] wlevel_q;
   logic full_q;
   logic almost_full_flag_q;
   logic unf_seen_q;
   // Read-side controller state
   logic [PW-1:0] rptr_q;
   logic [PW-1:0] rgray_q;
   logic empty_q;
   logic almost_empty_flag_q;
   logic unf_tgl_q;
   logic [DATA_W-1:0] rd_stage_q;
   logic [DATA_W-1:0] rd_data_q;
   // Crossing wires
   logic [PW-1:0] wgray_s;
   logic [PW:0] rx_s;
   logic [CW-1:0] cfg_s;

   // Bus decode
   logic bus_req;
   logic wr_acc;
   logic [31:0] rd_mux;
   logic [erf_pkg::EV_W-1:0] clr_mask;
   logic [erf_pkg::EV_W-1:0] ev;
   logic [erf_pkg::EV_W-1:0] stat_d;
   assign bus_req = avs_read | avs_write;
   assign wr_acc = avs_write & ~wait_q;
   assign clr_mask = (wr_acc && avs_address == erf_pkg::OFS_CLR) ? avs_writedata[erf_pkg::EV_W-1:0] : '0;

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      rd_mux = '0;
      if (avs_address == erf_pkg::OFS_CTRL) begin
         rd_mux[1:0] = ctrl_q;
      end else if (avs_address == erf_pkg::OFS_POL) begin
         rd_mux[7:0] = pol_q;
      end else if (avs_address == erf_pkg::OFS_ALMOST_FULL_FLAG) begin
         rd_mux[PW-1:0] = almost_full_flag_thr_q;
      end else if (avs_address == erf_pkg::OFS_ALMOST_EMPTY_FLAG) begin
         rd_mux[PW-1:0] = almost_empty_flag_thr_q;
      end else if (avs_address == erf_pkg::OFS_LEVEL) begin
         rd_mux[PW-1:0] = wlevel_q;
         rd_mux[erf_pkg::LEVEL_FULL_BIT] = full_q;
         rd_mux[erf_pkg::LEVEL_ALMOST_FULL_FLAG_BIT] = almost_full_flag_q;
      end else if (avs_address == erf_pkg::OFS_STAT) begin
         rd_mux[erf_pkg::EV_W-1:0] = stat_q;
      end else if (avs_address == erf_pkg::OFS_IEN) begin
         rd_mux[erf_pkg::EV_W-1:0] = ien_q;
      end
   end

   // Slave handshake: waitrequest drops one cycle after a request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else begin
         wait_q <= ~(bus_req & wait_q);
         if (avs_read && wait_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Writable registers take effect at the accepting edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= erf_pkg::CTRL_RST;
         pol_q <= erf_pkg::POL_RST;
         almost_full_flag_thr_q <= AF_RST;
         almost_empty_flag_thr_q <= AE_RST;
         ien_q <= erf_pkg::IEN_RST;
      end else if (wr_acc) begin
         if (avs_address == erf_pkg::OFS_CTRL) begin
            ctrl_q <= avs_writedata[1:0];
         end else if (avs_address == erf_pkg::OFS_POL) begin
            pol_q <= avs_writedata[7:0];
         end else if (avs_address == erf_pkg::OFS_ALMOST_FULL_FLAG) begin
            almost_full_flag_thr_q <= avs_writedata[PW-1:0];
         end else if (avs_address == erf_pkg::OFS_ALMOST_EMPTY_FLAG) begin
            almost_empty_flag_thr_q <= avs_writedata[PW-1:0];
         end else if (avs_address == erf_pkg::OFS_IEN) begin
            ien_q <= avs_writedata[erf_pkg::EV_W-1:0];
         end
      end
   end

   // Write-port decode; enables match their programmed polarity
   logic fifo_w;
   logic wsel;
   logic wr_go;
   logic wr_clr;
   logic wr_push;
   logic wr_ovf;
   logic [ADDR_W-1:0] waddr;
   logic [PW-1:0] wptr_d;
   logic [PW-1:0] rbin_s;
   logic [PW-1:0] wlevel_d;
   logic full_d;
   logic almost_full_flag_d;
   assign fifo_w = ctrl_q[erf_pkg::CTRL_MODE_BIT]; // R1
   assign wsel = &(wr_blk_en ~^ pol_q[3:0]); // R8
   assign wr_go = wr_en & wsel; // R9
   assign wr_clr = fifo_clr | ~fifo_w; // R6
   assign wr_push = wr_go & fifo_w & ~full_q & ~fifo_clr; // R5
   assign wr_ovf = wr_go & fifo_w & (full_q | fifo_clr);
   assign waddr = fifo_w ? wptr_q[ADDR_W-1:0] : write_addr; // R7
   assign wptr_d = wr_clr ? '0 : wptr_q + PW'(wr_push); // R12
   assign rbin_s = gray2bin(rx_s[PW-1:0]); // R5
   assign wlevel_d = wptr_d - rbin_s;
   assign full_d = ~wr_clr & wlevel_d[ADDR_W]; // R4
   assign almost_full_flag_d = ~wr_clr & (wlevel_d >= almost_full_flag_thr_q); // R4

   // Array write; a refused FIFO write leaves the array alone
   always_ff @(posedge clk) begin
      if (wr_go && (!fifo_w || wr_push)) begin // R2
         mem[waddr] <= write_data_bus;
      end
   end

   // Write pointer, its gray copy and the write-side flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_q <= '0;
         wgray_q <= '0;
         wlevel_q <= '0;
         full_q <= 1'b0;
         almost_full_flag_q <= 1'b0;
      end else begin
         wptr_q <= wptr_d;
         wgray_q <= bin2gray(wptr_d); // R3
         wlevel_q <= wr_clr ? '0 : wlevel_d;
         full_q <= full_d;
         almost_full_flag_q <= almost_full_flag_d;
      end
   end

   // Read pointer and underflow toggle cross back into clk
   erf_sync #(.W(PW + 1)) u_sync_r2w (
      .clk(clk),
      .rst(rst),
      .d({unf_tgl_q, rgray_q}),
      .q(rx_s)
   );

   // Events: set wins over a same-cycle clear
   assign ev = {almost_full_flag_d & ~almost_full_flag_q, full_d & ~full_q, rx_s[PW] ^ unf_seen_q, wr_ovf};
   assign stat_d = (stat_q & ~clr_mask) | ev;

   // Sticky status and level interrupt
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= '0;
         unf_seen_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         unf_seen_q <= rx_s[PW];
         irq_q <= |(stat_q & ien_q);
      end
   end

   // Write pointer and static config cross into rclk
   erf_sync #(.W(PW)) u_sync_wptr (
      .clk(rclk),
      .rst(rst),
      .d(wgray_q),
      .q(wgray_s)
   );
   erf_sync #(.W(CW)) u_sync_cfg (
      .clk(rclk),
      .rst(rst),
      .d({ctrl_q, pol_q[7:4], almost_empty_flag_thr_q, fifo_clr}),
      .q(cfg_s)
   );

   // Read-port decode in the rclk domain
   logic clr_s;
   logic fifo_r;
   logic pipe_r;
   logic rsel;
   logic rd_go;
   logic rd_clr;
   logic rd_pop;
   logic rd_unf;
   logic rd_take;
   logic [ADDR_W-1:0] raddr;
   logic [PW-1:0] rptr_d;
   logic [PW-1:0] wbin_s;
   logic [PW-1:0] rlevel_d;
   logic [DATA_W-1:0] word_d;
   logic [DATA_W-1:0] rd_data_d;
   assign clr_s = cfg_s[0];
   assign fifo_r = cfg_s[CW-2];
   assign pipe_r = cfg_s[CW-1];
   assign rsel = &(rd_blk_en ~^ cfg_s[CW-3 -: erf_pkg::BLK_SEL_W]); // R8
   assign rd_go = rd_en & rsel;
   assign rd_clr = clr_s | ~fifo_r; // R6
   assign rd_pop = rd_go & fifo_r & ~empty_q & ~clr_s; // R5
   assign rd_unf = rd_go & fifo_r & (empty_q | clr_s);
   assign rd_take = rd_go & (~fifo_r | rd_pop);
   assign raddr = fifo_r ? rptr_q[ADDR_W-1:0] : read_addr; // R7
   assign rptr_d = rd_clr ? '0 : rptr_q + PW'(rd_pop); // R12
   assign wbin_s = gray2bin(wgray_s);
   assign rlevel_d = wbin_s - rptr_d;
   // Unselected block returns zero so the shared bus can be merged
   assign word_d = rd_take ? mem[raddr] : '0; // R9
   assign rd_data_d = pipe_r ? rd_stage_q : (rd_en ? word_d : rd_data_q); // R11

   // Read pointer, read-side flags and output registers
   always_ff @(posedge rclk or posedge rst) begin
      if (rst) begin
         rptr_q <= '0;
         rgray_q <= '0;
         empty_q <= 1'b1;
         almost_empty_flag_q <= 1'b1;
         unf_tgl_q <= 1'b0;
         rd_stage_q <= '0;
         rd_data_q <= '0;
      end else begin
         rptr_q <= rptr_d;
         rgray_q <= bin2gray(rptr_d); // R3
         empty_q <= rd_clr | (rlevel_d == '0); // R4
         almost_empty_flag_q <= rd_clr | (rlevel_d <= cfg_s[PW:1]); // R4
         unf_tgl_q <= unf_tgl_q ^ rd_unf;
         if (rd_en) begin
            rd_stage_q <= word_d; // R2
         end
         rd_data_q <= rd_data_d;
      end
   end

   // Outputs straight from flip-flops
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign full_flag = full_q;
   assign almost_full_flag = almost_full_flag_q;
   assign empty_flag = empty_q;
   assign almost_empty_flag = almost_empty_flag_q;
   assign rd_data = rd_data_q;
   assign irq = irq_q;
   // Checks on the write and bus domain
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_bus_ack;
      @(posedge clk) disable iff (rst) (bus_req && wait_q) |=> s_ack;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("waitrequest not one-cycle low"); // R2
   property p_no_overflow;
      @(posedge clk) disable iff (rst) (full_q && wr_go && !fifo_clr) |=> (wptr_q == $past(wptr_q));
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("write into full FIFO"); // R5
   property p_ram_write;
      @(posedge clk) disable iff (rst) (!fifo_w && wr_go) |=> (mem[$past(write_addr)] == $past(write_data_bus));
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("RAM write used wrong address"); // R6
   property p_fifo_push;
      @(posedge clk) disable iff (rst) (fifo_w && wr_go && !full_q && !fifo_clr) |=>
         (wptr_q == $past(wptr_q) + 1'b1) && (mem[$past(wptr_q[ADDR_W-1:0])] == $past(write_data_bus));
   endproperty
   a_fifo_push: assert property (p_fifo_push) else $error("FIFO push misrouted"); // R7
   property p_wgray_step;
      @(posedge clk) disable iff (rst) !$past(wr_clr) |-> ($countones(wgray_q ^ $past(wgray_q)) <= 1);
   endproperty
   a_wgray_step: assert property (p_wgray_step) else $error("write gray pointer jumped"); // R3
   property p_clr_write;
      @(posedge clk) disable iff (rst) fifo_clr |=> (!full_flag && !almost_full_flag && wptr_q == '0);
   endproperty
   a_clr_write: assert property (p_clr_write) else $error("clear left write flags set"); // R12
   property p_irq;
      @(posedge clk) disable iff (rst) (|(stat_q & ien_q)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missed enabled status"); // R4
   // Checks on the read domain
   property p_no_underflow;
      @(posedge rclk) disable iff (rst) (empty_q && rd_go) |=> (rptr_q == $past(rptr_q));
   endproperty
   a_no_underflow: assert property (p_no_underflow) else $error("read from empty FIFO"); // R5
   property p_clr_read;
      @(posedge rclk) disable iff (rst) clr_s |=> (empty_flag && almost_empty_flag && rptr_q == '0);
   endproperty
   a_clr_read: assert property (p_clr_read) else $error("clear left read flags wrong"); // R12
   sequence s_pipe_read;
      (pipe_r && rd_en) ##1 pipe_r;
   endsequence
   property p_pipe;
      @(posedge rclk) disable iff (rst) s_pipe_read |=> (rd_data == $past(word_d, 2));
   endproperty
   a_pipe: assert property (p_pipe) else $error("pipelined read latency wrong"); // R11
   property p_unselected;
      @(posedge rclk) disable iff (rst) (!pipe_r && rd_en && !rsel) |=> (rd_data == '0);
   endproperty
   a_unselected: assert property (p_unselected) else $error("unselected block drove data"); // R8
endmodule

// *** verification/erf_fabric_model.sv ***
// Purpose: User fabric logic on the write and read ports of the block
// Assumes: Caller waits for a task to return before the next one
// Notes: Released lines carry the inverse of their last value
`timescale 1ns/10ps
module erf_fabric_model #(
   parameter int DW = 9,
   parameter int AW = 9
) (
   // Clocks
   input wire logic clk,
   input wire logic rclk,
   // Write port
   output logic [DW-1:0] write_data_bus,
   output logic [AW-1:0] write_addr,
   output logic wr_en,
   // Read port
   output logic [AW-1:0] read_addr,
   output logic rd_en,
   input wire logic [DW-1:0] rd_data
);
   // Quiet ports from time zero
   initial begin
      write_data_bus = '0;
      write_addr = '0;
      wr_en = 1'b0;
      read_addr = '0;
      rd_en = 1'b0;
   end

   // One write, launched and dropped on clk edges only
   task automatic put(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      write_addr <= a;
      write_data_bus <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      write_addr <= ~a;
      write_data_bus <= ~d;
   endtask

   // One read; a pipelined read needs one more rclk edge before data is valid
   task automatic get(input logic [AW-1:0] a, input bit pipe, output logic [DW-1:0] d);
      @(posedge rclk);
      rd_en <= 1'b1;
      read_addr <= a;
      @(posedge rclk);
      rd_en <= 1'b0;
      read_addr <= ~a;
      if (pipe) begin
         @(posedge rclk);
      end
      #1 d = rd_data;
   endtask
endmodule

// *** verification/test_embedded_ram_fifo_block.sv ***
// Purpose: Self-checking bench for the RAM/FIFO block
// Assumes: Default 9x9 shape, so the FIFO is 512 deep
// Notes: Read clock is unrelated to clk; flag waits allow for the crossing
`timescale 1ns/10ps
module test_embedded_ram_fifo_block;
   localparam int DW = erf_pkg::DATA_W_DEF;
   localparam int AW = erf_pkg::ADDR_W_DEF;
   localparam int DEPTH = 1 << AW;
   logic clk = 1'b0;
   logic rclk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [DW-1:0] write_data_bus, rd_data, d;
   logic [AW-1:0] write_addr, read_addr;
   logic wr_en, rd_en, full_flag, almost_full_flag, empty_flag, almost_empty_flag, irq;
   logic [3:0] wr_blk_en = 4'hF;
   logic [3:0] rd_blk_en = 4'hF;
   logic fifo_clr = 1'b0;
   int n_mismatch = 0;
   int check_count = 0;

   // Bus clock 100 ns; read clock on an unrelated period
   always #50 clk = ~clk;
   always #68.5 rclk = ~rclk;

   erf_ram_fifo dut (.clk, .rst, .rclk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .write_data_bus, .write_addr, .wr_en, .wr_blk_en,
      .read_addr, .rd_en, .rd_blk_en, .rd_data, .fifo_clr, .full_flag, .almost_full_flag,
      .empty_flag, .almost_empty_flag, .irq);
   erf_fabric_model #(.DW(DW), .AW(AW)) fab (.clk, .rclk, .write_data_bus, .write_addr, .wr_en,
      .read_addr, .rd_en, .rd_data);

   // Compare one value; every mismatch reported at once
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Flag pins in the order full, almost full, empty, almost empty
   task automatic flags_are(input string what, input logic [3:0] exp);
      check(what, {28'h0, exp}, {28'h0, full_flag, almost_full_flag, empty_flag, almost_empty_flag});
   endtask

   // Avalon access: request held until waitrequest is sampled low
   task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50) check("waitrequest", 32'h0, 32'h1);
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] r;
      bus(1'b1, a, v, r);
   endtask

   task automatic reg_is(input string what, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(what, exp, r);
   endtask

   function automatic logic [DW-1:0] pat(input int i);
      return DW'(i * 37 + 11);
   endfunction

   task automatic rwait(input int n);
      repeat (n) @(posedge rclk);
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // Reset state of registers and flags
      reg_is("ctrl", erf_pkg::OFS_CTRL, 32'h0);
      reg_is("pol", erf_pkg::OFS_POL, 32'hFF);
      reg_is("almost_full_flag thr", erf_pkg::OFS_ALMOST_FULL_FLAG, DEPTH - 1);
      reg_is("almost_empty_flag thr", erf_pkg::OFS_ALMOST_EMPTY_FLAG, 32'h1);
      reg_is("ien", erf_pkg::OFS_IEN, 32'h0);
      reg_is("stat", erf_pkg::OFS_STAT, 32'h0);
      flags_are("reset flags", 4'b0011);
      check("irq", 32'h0, {31'h0, irq});
      $display("test reset done");
      // RAM mode, non-pipelined then pipelined
      for (int i = 0; i < 4; i++) fab.put(AW'(i), pat(100 + i));
      for (int i = 3; i >= 0; i--) begin
         fab.get(AW'(i), 1'b0, d);
         check("ram word", pat(100 + i), d);
      end
      flags_are("ram flags", 4'b0011);
      wr_reg(erf_pkg::OFS_CTRL, 32'h2);
      rwait(3);
      for (int i = 0; i < 4; i++) begin
         fab.get(AW'(i), 1'b1, d);
         check("pipe word", pat(100 + i), d);
      end
      $display("test ram done");
      // Enable polarity decode
      wr_reg(erf_pkg::OFS_CTRL, 32'h0);
      wr_reg(erf_pkg::OFS_POL, 32'hEE);
      rwait(3);
      fab.put(AW'(0), pat(7));
      fab.get(AW'(0), 1'b0, d);
      check("unselected read", 32'h0, 32'(d));
      @(posedge rclk) rd_blk_en <= 4'hE;
      fab.get(AW'(0), 1'b0, d);
      check("unselected write", pat(100), d);
      @(posedge clk) wr_blk_en <= 4'hE;
      fab.put(AW'(0), pat(7));
      fab.get(AW'(0), 1'b0, d);
      check("selected write", pat(7), d);
      wr_reg(erf_pkg::OFS_POL, 32'hFF);
      wr_blk_en <= 4'hF;
      rd_blk_en <= 4'hF;
      $display("test polarity done");
      // FIFO fill, thresholds, overflow and interrupt
      wr_reg(erf_pkg::OFS_CTRL, 32'h1);
      wr_reg(erf_pkg::OFS_ALMOST_FULL_FLAG, 32'h4);
      wr_reg(erf_pkg::OFS_ALMOST_EMPTY_FLAG, 32'h2);
      wr_reg(erf_pkg::OFS_IEN, 32'h1);
      rwait(3);
      for (int i = 0; i < 3; i++) fab.put(AW'(0), pat(i));
      #1 check("almost_full_flag below", 32'h0, {31'h0, almost_full_flag});
      fab.put(AW'(0), pat(3));
      #1 check("almost_full_flag at thr", 32'h1, {31'h0, almost_full_flag});
      rwait(4);
      flags_are("level four", 4'b0100);
      for (int i = 4; i < DEPTH; i++) fab.put(AW'(0), pat(i));
      #1 flags_are("full", 4'b1100);
      check("masked irq", 32'h0, {31'h0, irq});
      reg_is("level", erf_pkg::OFS_LEVEL, 32'h30000 | DEPTH);
      fab.put(AW'(0), pat(999));
      repeat (2) @(posedge clk);
      #1 check("irq raised", 32'h1, {31'h0, irq});
      reg_is("stat ovf", erf_pkg::OFS_STAT, 32'hD);
      wr_reg(erf_pkg::OFS_CLR, 32'h1);
      repeat (2) @(posedge clk);
      #1 check("irq cleared", 32'h0, {31'h0, irq});
      reg_is("stat after clr", erf_pkg::OFS_STAT, 32'hC);
      wr_reg(erf_pkg::OFS_CLR, 32'hC);
      $display("test fill done");
      // Drain in order, then underflow
      for (int i = 0; i < DEPTH; i++) begin
         fab.get(AW'(0), 1'b0, d);
         check("fifo word", pat(i), d);
      end
      rwait(4);
      flags_are("drained", 4'b0011);
      fab.get(AW'(0), 1'b0, d);
      check("underflow word", 32'h0, 32'(d));
      repeat (6) @(posedge clk);
      reg_is("stat unf", erf_pkg::OFS_STAT, 32'h2);
      wr_reg(erf_pkg::OFS_CLR, 32'h2);
      $display("test drain done");
      // Clear with words pending
      for (int i = 0; i < 5; i++) fab.put(AW'(0), pat(50 + i));
      @(posedge clk);
      fifo_clr <= 1'b1;
      repeat (6) @(posedge clk);
      fifo_clr <= 1'b0;
      rwait(4);
      flags_are("cleared", 4'b0011);
      reg_is("level cleared", erf_pkg::OFS_LEVEL, 32'h0);
      fab.put(AW'(0), pat(77));
      rwait(4);
      fab.get(AW'(0), 1'b0, d);
      check("first after clear", pat(77), d);
      // Pipelined FIFO mode, otherwise never set
      wr_reg(erf_pkg::OFS_CTRL, 32'h3);
      rwait(3);
      fab.put(AW'(0), pat(78));
      rwait(4);
      fab.get(AW'(0), 1'b1, d);
      check("pipe fifo word", pat(78), d);
      rwait(4);
      flags_are("pipe drained", 4'b0011);
      $display("test clear done");
      final_report();
   end
endmodule
